// ===== hw/framer_dev.sv
`timescale 1ns/100ps
module framer_dev
  import framer_pkg::*;
(
  // Clock and reset
  input  wire logic                          clk_sys_i,
  input  wire logic                          rstn_i,
  // Link to host
  framer_if.dev_end                          link,
  // Decode results toward quantizer and video side
  output logic                               fld_start_o,
  output logic                               fld_two_o,
  output logic                               blk_start_o,
  output logic [framer_pkg::TAG_W-1:0]       blk_model_o,
  output logic [framer_pkg::STEP_W-1:0]      quant_step_o,
  output logic                               blk_zero_o,
  output logic                               ent_reset_o,
  output logic                               seq_end_o,
  output logic [framer_pkg::WORD_W-1:0]      pay_data_o,
  output logic                               pay_valid_o,
  // Encode payload from entropy coder, reciprocal step toward quantizer
  input  wire logic [framer_pkg::WORD_W-1:0] enc_word_i,
  input  wire logic [framer_pkg::BITS_W-1:0] enc_bits_i,
  input  wire logic                          enc_last_i,
  input  wire logic                          enc_word_valid_i,
  output logic                               enc_word_ready_o,
  output logic [framer_pkg::STEP_W-1:0]      quant_recip_o
);
  import framer_pkg::*;

  typedef enum logic [1:0] {
    D_HUNT  = 2'b00,
    D_FIELD = 2'b01,
    D_BLOCK = 2'b10,
    D_ZERO  = 2'b11
  } dec_state_e;

  typedef enum logic [1:0] {
    E_IDLE = 2'b00,
    E_PRE  = 2'b01,
    E_HDR  = 2'b10,
    E_PAY  = 2'b11
  } enc_state_e;

  // Keep the top bits valid, fill the rest with ones
  function automatic logic [31:0] pad_ones(input logic [31:0] w, input logic [5:0] n);
    if (n == 6'h00 || n >= 6'h20)
      pad_ones = w;
    else
      pad_ones = w | (ONES_WORD >> n);
  endfunction

  dec_state_e  d_state_reg, d_state_next;
  logic        prev_ones_reg, prev_ones_next;
  logic        first_reg, first_next;
  logic [31:0] held_reg, held_next;
  logic        held_v_reg, held_v_next;
  logic        fld_start_next, fld_two_next, blk_start_next, blk_zero_next;
  logic        ent_reset_next, seq_end_next, pay_valid_next;
  logic [7:0]  blk_model_next;
  logic [15:0] quant_step_next;
  logic [31:0] pay_data_next;
  logic        delim, is_field, is_two, is_block, is_zero, is_eos;
  logic        in_fire, type_code;

  delim_detect u_detect (
    .word_i      (link.dec_data),
    .prev_ones_i (prev_ones_reg),
    .delim_o     (delim),
    .field_o     (is_field),
    .field_two_o (is_two),
    .block_o     (is_block),
    .zero_blk_o  (is_zero),
    .eos_o       (is_eos)
  );

  always_comb
  begin
    in_fire         = link.dec_valid && link.dec_ready;
    type_code       = link.dec_data[31:24] >= TAG_M1_CHR && link.dec_data[31:24] <= TAG_M2_LUM;
    d_state_next    = d_state_reg;
    prev_ones_next  = prev_ones_reg;
    first_next      = first_reg;
    held_next       = held_reg;
    held_v_next     = held_v_reg;
    fld_start_next  = 1'b0;
    fld_two_next    = fld_two_o;
    blk_start_next  = 1'b0;
    blk_zero_next   = blk_zero_o;
    blk_model_next  = blk_model_o;
    quant_step_next = quant_step_o;
    ent_reset_next  = 1'b0;
    seq_end_next    = 1'b0;
    pay_valid_next  = 1'b0;
    pay_data_next   = pay_data_o;
    if (in_fire)
    begin
      prev_ones_next = (link.dec_data == ONES_WORD) && !delim; // R01
      if (is_field)
      begin
        d_state_next   = D_FIELD; // R16
        fld_start_next = 1'b1;
        fld_two_next   = is_two; // R12
        ent_reset_next = 1'b1; // R12
        first_next     = 1'b1;
        held_v_next    = 1'b0;
      end
      else if (d_state_reg == D_HUNT)
      begin
        held_v_next = 1'b0; // R16
      end
      else if (is_eos)
      begin
        d_state_next   = D_HUNT;
        seq_end_next   = 1'b1;
        ent_reset_next = d_state_reg == D_BLOCK; // R08
        held_v_next    = 1'b0;
      end
      else if (is_block || (d_state_reg == D_FIELD && first_reg && type_code))
      begin
        // Tag, raw step word, then entropy payload words
        first_next      = 1'b0;
        blk_start_next  = 1'b1; // R13
        blk_model_next  = link.dec_data[31:24]; // R15
        quant_step_next = is_zero ? STEP_RESET : link.dec_data[23:8]; // R02 R03
        blk_zero_next   = is_zero || link.dec_data[23:8] == STEP_RESET; // R04 R14
        d_state_next    = blk_zero_next ? D_ZERO : D_BLOCK; // R14
        ent_reset_next  = d_state_reg == D_BLOCK; // R08
        held_v_next     = 1'b0; // R08
      end
      else if (d_state_reg == D_BLOCK)
      begin
        // One word behind so an all-ones prefix is never passed on
        pay_valid_next = held_v_reg; // R11
        pay_data_next  = held_reg;
        held_next      = link.dec_data;
        held_v_next    = 1'b1;
      end
      else
      begin
        held_v_next = 1'b0; // R04
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      d_state_reg   <= D_HUNT;
      prev_ones_reg <= 1'b0;
      first_reg     <= 1'b0;
      held_reg      <= 32'h0000_0000;
      held_v_reg    <= 1'b0;
      fld_start_o   <= 1'b0;
      fld_two_o     <= 1'b0;
      blk_start_o   <= 1'b0;
      blk_zero_o    <= 1'b0;
      blk_model_o   <= 8'h00;
      quant_step_o  <= STEP_RESET;
      ent_reset_o   <= 1'b0;
      seq_end_o     <= 1'b0;
      pay_valid_o   <= 1'b0;
      pay_data_o    <= 32'h0000_0000;
      link.dec_ready <= 1'b0;
    end
    else
    begin
      d_state_reg   <= d_state_next;
      prev_ones_reg <= prev_ones_next;
      first_reg     <= first_next;
      held_reg      <= held_next;
      held_v_reg    <= held_v_next;
      fld_start_o   <= fld_start_next;
      fld_two_o     <= fld_two_next;
      blk_start_o   <= blk_start_next;
      blk_zero_o    <= blk_zero_next;
      blk_model_o   <= blk_model_next;
      quant_step_o  <= quant_step_next;
      ent_reset_o   <= ent_reset_next;
      seq_end_o     <= seq_end_next;
      pay_valid_o   <= pay_valid_next;
      pay_data_o    <= pay_data_next;
      link.dec_ready <= 1'b1;
    end
  end

  // Encode side
  enc_state_e  e_state_reg, e_state_next;
  logic [7:0]  e_tag_reg, e_tag_next;
  logic [15:0] e_step_reg, e_step_next;
  logic [15:0] recip_next;
  logic [31:0] out_data_next;
  logic        out_valid_next, cmd_ready_next, word_ready_next, free;

  always_comb
  begin
    free            = !link.enc_valid || link.enc_ready;
    e_state_next    = e_state_reg;
    e_tag_next      = e_tag_reg;
    e_step_next     = e_step_reg;
    recip_next      = quant_recip_o;
    out_data_next   = link.enc_data;
    out_valid_next  = link.enc_valid && !link.enc_ready;
    cmd_ready_next  = 1'b0;
    word_ready_next = 1'b0;
    case (e_state_reg)
      E_IDLE:
      begin
        cmd_ready_next = 1'b1;
        if (link.cmd_valid && link.cmd_ready)
        begin
          e_tag_next     = link.cmd_tag;
          e_step_next    = link.cmd_step; // R05
          recip_next     = link.cmd_recip; // R06
          cmd_ready_next = 1'b0;
          e_state_next   = E_PRE;
        end
      end
      E_PRE:
      begin
        if (free)
        begin
          out_data_next  = ONES_WORD; // R01
          out_valid_next = 1'b1;
          e_state_next   = E_HDR;
        end
      end
      E_HDR:
      begin
        if (free)
        begin
          out_data_next  = {e_tag_reg, e_step_reg, 8'hff}; // R05 R13
          out_valid_next = 1'b1;
          e_state_next   = E_PAY;
        end
      end
      default:
      begin
        if (enc_word_ready_o && enc_word_valid_i)
        begin
          out_data_next  = pad_ones(enc_word_i, enc_bits_i); // R07
          out_valid_next = 1'b1;
          // Block closes with its payload, never with a sequence end
          if (enc_last_i)
            e_state_next = E_IDLE; // R10
        end
        else
        begin
          word_ready_next = free;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      e_state_reg      <= E_IDLE;
      e_tag_reg        <= 8'h00;
      e_step_reg       <= STEP_RESET;
      quant_recip_o    <= STEP_RESET;
      link.enc_data    <= 32'h0000_0000;
      link.enc_valid   <= 1'b0;
      link.cmd_ready   <= 1'b0;
      enc_word_ready_o <= 1'b0;
    end
    else
    begin
      e_state_reg      <= e_state_next;
      e_tag_reg        <= e_tag_next;
      e_step_reg       <= e_step_next;
      quant_recip_o    <= recip_next;
      link.enc_data    <= out_data_next;
      link.enc_valid   <= out_valid_next;
      link.cmd_ready   <= cmd_ready_next;
      enc_word_ready_o <= word_ready_next;
    end
  end
endmodule

// ===== inc/framer_pkg.sv
// Operation
// R01 - Delimiters sit on 32-bit word boundaries
// R02 - Step word: 16-bit raw unsigned 8.8 value
// R03 - Decode passes parsed step word to quantizer
// R04 - Zero step: payload consumed, coefficients zeroed
// R05 - Encode inserts host step word, unused locally
// R06 - Encode quantizer uses host reciprocal step value
// R07 - Encoder pads payload tail with ones
// R08 - Delimiter mid-payload resets entropy decoding
// R09 - Host sends end-of-sequence after last field
// R10 - Encoder never emits end-of-sequence marker
// R11 - Payload bit errors never fake delimiters
// R12 - Field starts reset decode, select field
// R13 - Block start carries model, step, payload
// R14 - Zero-block start: block taken as zero
// R15 - First block type code selects model
// R16 - After reset, wait for field start
package framer_pkg;
  localparam int          WORD_W       = 32;
  localparam int          STEP_W       = 16;
  localparam int          TAG_W        = 8;
  localparam int          BITS_W       = 6;
  localparam logic [31:0] ONES_WORD    = 32'hffff_ffff;
  localparam logic [7:0]  TAG_FIELD1   = 8'h40;
  localparam logic [7:0]  TAG_FIELD2   = 8'h41;
  localparam logic [7:0]  TAG_EOS      = 8'hc0;
  localparam logic [7:0]  TAG_M1_CHR   = 8'h81;
  localparam logic [7:0]  TAG_M1_LUM   = 8'h82;
  localparam logic [7:0]  TAG_M2_CHR   = 8'h83;
  localparam logic [7:0]  TAG_M2_LUM   = 8'h84;
  localparam logic [7:0]  TAG_ZERO_BLK = 8'h8f;
  localparam logic [31:0] EOS_WORD     = 32'hc0ff_ffff;
  localparam logic [15:0] STEP_RESET   = 16'h0000;
  localparam logic [1:0]  EOS_WORDS    = 2'h2;
endpackage

// ===== inc/framer_if.sv
`timescale 1ns/100ps
interface framer_if;
  import framer_pkg::*;
  // Compressed words toward the device (decode)
  logic [31:0] dec_data;
  logic        dec_valid;
  logic        dec_ready;
  // Compressed words toward the host (encode)
  logic [31:0] enc_data;
  logic        enc_valid;
  logic        enc_ready;
  // Per-block encode command from the host
  logic [7:0]  cmd_tag;
  logic [15:0] cmd_step;
  logic [15:0] cmd_recip;
  logic        cmd_valid;
  logic        cmd_ready;

  modport dev_end (
    input  dec_data, dec_valid, enc_ready, cmd_tag, cmd_step, cmd_recip, cmd_valid,
    output dec_ready, enc_data, enc_valid, cmd_ready
  );
  modport host_end (
    output dec_data, dec_valid, enc_ready, cmd_tag, cmd_step, cmd_recip, cmd_valid,
    input  dec_ready, enc_data, enc_valid, cmd_ready
  );
endinterface

// ===== hw/delim_detect.sv
`timescale 1ns/100ps
module delim_detect
  import framer_pkg::*;
(
  input  wire logic [framer_pkg::WORD_W-1:0] word_i,
  input  wire logic                          prev_ones_i,
  output logic                               delim_o,
  output logic                               field_o,
  output logic                               field_two_o,
  output logic                               block_o,
  output logic                               zero_blk_o,
  output logic                               eos_o
);
  logic [7:0] tag;

  always_comb
  begin
    tag         = word_i[31:24];
    // Only a whole all-ones word followed by a tag word counts
    field_o     = prev_ones_i && (word_i == {TAG_FIELD1, 24'h00_0000} ||
                                  word_i == {TAG_FIELD2, 24'h00_0000}); // R01
    field_two_o = field_o && (tag == TAG_FIELD2); // R12
    eos_o       = prev_ones_i && (word_i == EOS_WORD);
    block_o     = prev_ones_i && ((tag >= TAG_M1_CHR && tag <= TAG_M2_LUM) ||
                                  tag == TAG_ZERO_BLK); // R11
    zero_blk_o  = block_o && (tag == TAG_ZERO_BLK); // R14
    delim_o     = field_o || eos_o || block_o;
  end
endmodule

// ===== hw/framer_host.sv
`timescale 1ns/100ps
module framer_host
  import framer_pkg::*;
(
  // Clock and reset
  input  wire logic                          clk_sys_i,
  input  wire logic                          rstn_i,
  // Link to device
  framer_if.host_end                         link,
  // Words to decode
  input  wire logic [framer_pkg::WORD_W-1:0] send_word_i,
  input  wire logic                          send_valid_i,
  output logic                               send_ready_o,
  input  wire logic                          send_eos_i,
  // Block command for encode
  input  wire logic [framer_pkg::TAG_W-1:0]  cmd_tag_i,
  input  wire logic [framer_pkg::STEP_W-1:0] cmd_step_i,
  input  wire logic [framer_pkg::STEP_W-1:0] cmd_recip_i,
  input  wire logic                          cmd_valid_i,
  output logic                               cmd_ready_o,
  // Encoded words received
  output logic [framer_pkg::WORD_W-1:0]      recv_word_o,
  output logic                               recv_valid_o
);
  import framer_pkg::*;

  logic [1:0]  eos_cnt_reg, eos_cnt_next;
  logic [31:0] data_next;
  logic        valid_next, ready_next, free;
  logic        cvalid_next, cready_next;
  logic [7:0]  ctag_next;
  logic [15:0] cstep_next, crecip_next;

  always_comb
  begin
    free         = !link.dec_valid || link.dec_ready;
    eos_cnt_next = eos_cnt_reg;
    data_next    = link.dec_data;
    valid_next   = link.dec_valid && !link.dec_ready;
    ready_next   = 1'b0;
    if (send_eos_i)
      eos_cnt_next = EOS_WORDS; // R09
    if (send_ready_o && send_valid_i)
    begin
      data_next  = send_word_i;
      valid_next = 1'b1;
    end
    else if (free && eos_cnt_reg != 2'h0)
    begin
      // Sequence end is the host's own job
      data_next    = eos_cnt_reg == EOS_WORDS ? ONES_WORD : EOS_WORD; // R09 R10
      valid_next   = 1'b1;
      eos_cnt_next = eos_cnt_reg - 2'h1;
    end
    else
    begin
      ready_next = free && eos_cnt_reg == 2'h0 && !send_eos_i;
    end
    cvalid_next = link.cmd_valid && !link.cmd_ready;
    cready_next = 1'b0;
    ctag_next   = link.cmd_tag;
    cstep_next  = link.cmd_step;
    crecip_next = link.cmd_recip;
    if (cmd_ready_o && cmd_valid_i)
    begin
      cvalid_next = 1'b1;
      ctag_next   = cmd_tag_i;
      cstep_next  = cmd_step_i; // R05
      crecip_next = cmd_recip_i; // R06
    end
    else
    begin
      cready_next = !link.cmd_valid || link.cmd_ready;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      eos_cnt_reg    <= 2'h0;
      link.dec_data  <= 32'h0000_0000;
      link.dec_valid <= 1'b0;
      send_ready_o   <= 1'b0;
      link.cmd_valid <= 1'b0;
      link.cmd_tag   <= 8'h00;
      link.cmd_step  <= STEP_RESET;
      link.cmd_recip <= STEP_RESET;
      cmd_ready_o    <= 1'b0;
      link.enc_ready <= 1'b0;
      recv_word_o    <= 32'h0000_0000;
      recv_valid_o   <= 1'b0;
    end
    else
    begin
      eos_cnt_reg    <= eos_cnt_next;
      link.dec_data  <= data_next;
      link.dec_valid <= valid_next;
      send_ready_o   <= ready_next;
      link.cmd_valid <= cvalid_next;
      link.cmd_tag   <= ctag_next;
      link.cmd_step  <= cstep_next;
      link.cmd_recip <= crecip_next;
      cmd_ready_o    <= cready_next;
      link.enc_ready <= 1'b1;
      recv_word_o    <= link.enc_valid ? link.enc_data : recv_word_o;
      recv_valid_o   <= link.enc_valid && link.enc_ready;
    end
  end
endmodule

// ===== bench/framer_asserts.sv
`timescale 1ns/100ps
module framer_asserts
  import framer_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys_i,
  input wire logic        rstn_i,
  // Link signals
  input wire logic [31:0] dec_data,
  input wire logic        dec_valid,
  input wire logic        dec_ready,
  input wire logic [31:0] enc_data,
  input wire logic        enc_valid,
  input wire logic        enc_ready,
  input wire logic [7:0]  cmd_tag,
  input wire logic [15:0] cmd_step,
  input wire logic [15:0] cmd_recip,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready
);
  logic        pend_reg;
  logic        pend_next;
  logic [23:0] hdr_reg;
  logic [23:0] hdr_next;
  logic        hdr_seen;

  // Header owed after each accepted command
  assign hdr_seen = enc_valid && enc_ready && pend_reg && enc_data != ONES_WORD;
  always_comb
  begin
    pend_next = pend_reg;
    hdr_next  = hdr_reg;
    if (cmd_valid && cmd_ready)
    begin
      pend_next = 1'b1;
      hdr_next  = {cmd_tag, cmd_step};
    end
    else if (hdr_seen)
      pend_next = 1'b0;
  end
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pend_reg <= 1'b0;
      hdr_reg  <= 24'h00_0000;
    end
    else
    begin
      pend_reg <= pend_next;
      hdr_reg  <= hdr_next;
    end
  end

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  a_hdr_fields: assert property (hdr_seen |-> enc_data == {hdr_reg, 8'hff})
    else $error("encode header differs from command");
  a_ones_before_hdr: assert property (hdr_seen |->
    $past(enc_valid && enc_ready && enc_data == ONES_WORD))
    else $error("header not preceded by ones word");
  a_enc_no_eos: assert property (enc_valid |-> enc_data != EOS_WORD)
    else $error("encoder emitted end of sequence");
  a_cmd_to_ones: assert property (cmd_valid && cmd_ready |->
    ##[1:4] (enc_valid && enc_data == ONES_WORD))
    else $error("no ones word after command");
  a_cmd_ready_drop: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("second command accepted in block");
  a_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_tag)
    && $stable(cmd_step) && $stable(cmd_recip))
    else $error("command changed while waiting");
  a_eos_after_ones: assert property (dec_valid && dec_ready && dec_data == EOS_WORD |->
    $past(dec_valid && dec_ready && dec_data == ONES_WORD))
    else $error("end of sequence without ones prefix");
  a_dec_always_rdy: assert property ($past(rstn_i) |-> dec_ready)
    else $error("decode link not ready");
endmodule

// ===== bench/tb.sv
`timescale 1ns/100ps
`define CHK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module tb;
  import framer_pkg::*;
  logic        clk_sys_i;
  logic        rstn_i;
  logic        fld_start_o;
  logic        fld_two_o;
  logic        blk_start_o;
  logic [7:0]  blk_model_o;
  logic [15:0] quant_step_o;
  logic        blk_zero_o;
  logic        ent_reset_o;
  logic        seq_end_o;
  logic [31:0] pay_data_o;
  logic        pay_valid_o;
  logic [31:0] enc_word_i;
  logic [5:0]  enc_bits_i;
  logic        enc_last_i;
  logic        enc_word_valid_i;
  logic        enc_word_ready_o;
  logic [15:0] quant_recip_o;
  logic [31:0] send_word_i;
  logic        send_valid_i;
  logic        send_ready_o;
  logic        send_eos_i;
  logic [7:0]  cmd_tag_i;
  logic [15:0] cmd_step_i;
  logic [15:0] cmd_recip_i;
  logic        cmd_valid_i;
  logic        cmd_ready_o;
  logic [31:0] recv_word_o;
  logic        recv_valid_o;
  int          failures;
  int          tests_run;
  int          cyc;
  int          n_fld;
  int          n_seq;
  logic [31:0] exp_pay[$];
  logic [31:0] got_pay[$];
  logic [31:0] exp_rcv[$];
  logic [31:0] got_rcv[$];
  logic [24:0] exp_blk[$];
  logic [24:0] got_blk[$];
  logic [7:0]  tags[5] = '{TAG_M1_CHR, TAG_M1_LUM, TAG_M2_CHR, TAG_M2_LUM, TAG_ZERO_BLK};
  logic [5:0]  bits_tab[4] = '{6'd1, 6'd31, 6'd0, 6'd32};

  framer_if lnk ();
  framer_dev framer_dev_i (.clk_sys_i, .rstn_i, .link(lnk), .fld_start_o, .fld_two_o,
    .blk_start_o, .blk_model_o, .quant_step_o, .blk_zero_o, .ent_reset_o, .seq_end_o,
    .pay_data_o, .pay_valid_o, .enc_word_i, .enc_bits_i, .enc_last_i, .enc_word_valid_i,
    .enc_word_ready_o, .quant_recip_o);
  framer_host framer_host_i (.clk_sys_i, .rstn_i, .link(lnk), .send_word_i, .send_valid_i,
    .send_ready_o, .send_eos_i, .cmd_tag_i, .cmd_step_i, .cmd_recip_i, .cmd_valid_i,
    .cmd_ready_o, .recv_word_o, .recv_valid_o);
  framer_asserts framer_asserts_i (.clk_sys_i, .rstn_i, .dec_data(lnk.dec_data),
    .dec_valid(lnk.dec_valid), .dec_ready(lnk.dec_ready), .enc_data(lnk.enc_data),
    .enc_valid(lnk.enc_valid), .enc_ready(lnk.enc_ready), .cmd_tag(lnk.cmd_tag),
    .cmd_step(lnk.cmd_step), .cmd_recip(lnk.cmd_recip), .cmd_valid(lnk.cmd_valid),
    .cmd_ready(lnk.cmd_ready));

  initial
  begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  // Outputs are settled at the falling edge
  always @(negedge clk_sys_i)
  begin
    if (pay_valid_o === 1'b1) got_pay.push_back(pay_data_o);
    if (blk_start_o === 1'b1) got_blk.push_back({blk_model_o, quant_step_o, blk_zero_o});
    if (recv_valid_o === 1'b1) got_rcv.push_back(recv_word_o);
    if (seq_end_o === 1'b1)
    begin
      n_seq++;
      // Sequence end lands inside a payload
      `CHK(ent_reset_o, 1'b1)
    end
    if (fld_start_o === 1'b1)
    begin
      n_fld++;
      `CHK(ent_reset_o, 1'b1)
    end
  end

  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      finish_test();
    end
  end

  function automatic logic [24:0] blk_exp(logic [7:0] t, logic [15:0] s);
    logic z;
    z = (t == TAG_ZERO_BLK) || (s == STEP_RESET);
    return {t, z ? STEP_RESET : s, z};
  endfunction

  function automatic logic [31:0] pad(logic [31:0] w, logic [5:0] b);
    return (b == 6'd0 || b >= 6'd32) ? w : w | (ONES_WORD >> b);
  endfunction

  function automatic logic rdy(int s);
    return s == 0 ? send_ready_o : s == 1 ? cmd_ready_o : enc_word_ready_o;
  endfunction

  task automatic hs(int s);
    int n;
    n = 0;
    do
    begin
      @(negedge clk_sys_i);
      n++;
    end
    while (rdy(s) !== 1'b1 && n < 64);
    @(posedge clk_sys_i);
  endtask

  task automatic snd(logic [31:0] w);
    send_word_i  <= w;
    send_valid_i <= 1'b1;
    hs(0);
  endtask

  task automatic pw(logic [31:0] w, bit keep);
    snd(w);
    if (keep)
      exp_pay.push_back(w);
  endtask

  task automatic blk(logic [7:0] t, logic [15:0] s, int len, bit pre);
    logic [24:0] e;
    e = blk_exp(t, s);
    if (pre)
      snd(ONES_WORD);
    snd({t, s, 8'hff});
    exp_blk.push_back(e);
    repeat (len)
      pw($urandom & 32'h7fff_ffff, !e[0]);
  endtask

  task automatic enc_blk(logic [7:0] t, logic [5:0] b, int len);
    logic [15:0] s;
    logic [15:0] r;
    logic [31:0] w;
    int          n;
    s = 16'($urandom);
    r = 16'($urandom);
    cmd_tag_i   <= t;
    cmd_step_i  <= s;
    cmd_recip_i <= r;
    cmd_valid_i <= 1'b1;
    hs(1);
    cmd_valid_i <= 1'b0;
    exp_rcv.push_back(ONES_WORD);
    exp_rcv.push_back({t, s, 8'hff});
    for (int i = 1; i <= len; i++)
    begin
      w = $urandom & 32'h7fff_ffff;
      enc_word_i       <= w;
      enc_bits_i       <= (i == len) ? b : 6'd0;
      enc_last_i       <= (i == len);
      enc_word_valid_i <= 1'b1;
      hs(2);
      enc_word_valid_i <= 1'b0;
      exp_rcv.push_back(pad(w, (i == len) ? b : 6'd0));
      @(posedge clk_sys_i);
    end
    n = 0;
    while (got_rcv.size() < exp_rcv.size() && n < 64)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    `CHK(quant_recip_o, r)
  endtask

  task finish_test;
    if (failures == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    rstn_i = 1'b0;
    {send_word_i, send_valid_i, send_eos_i, cmd_tag_i, cmd_step_i, cmd_recip_i} = '0;
    {cmd_valid_i, enc_word_i, enc_bits_i, enc_last_i, enc_word_valid_i} = '0;
    void'($urandom(32'hfce3));
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    // Junk ahead of any field start is dropped
    blk(TAG_M2_LUM, 16'h0010, 2, 1);
    exp_blk.delete();
    exp_pay.delete();
    snd(ONES_WORD);
    snd({TAG_FIELD1, 24'h00_0000});
    blk(TAG_M1_LUM, 16'($urandom_range(1, 65535)), 3, 0);
    `CHK(fld_two_o, 1'b0)
    foreach (tags[i])
      blk(tags[i], 16'($urandom_range(1, 65535)), $urandom_range(1, 4), 1);
    blk(TAG_M2_CHR, STEP_RESET, 2, 1);
    blk(TAG_M1_CHR, 16'h0100, 1, 1);
    pw(32'hffff_fffe, 1);
    pw(32'h4000_0000, 1);
    // Field two arrives inside a payload
    snd(ONES_WORD);
    snd({TAG_FIELD2, 24'h00_0000});
    blk(TAG_M2_LUM, 16'($urandom_range(1, 65535)), 2, 1);
    `CHK(fld_two_o, 1'b1)
    send_valid_i <= 1'b0;
    send_eos_i   <= 1'b1;
    @(posedge clk_sys_i);
    send_eos_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    blk(TAG_M1_CHR, 16'h0200, 2, 1);
    void'(exp_blk.pop_back());
    void'(exp_pay.pop_back());
    void'(exp_pay.pop_back());
    send_valid_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    `CHK(n_seq, 1)
    `CHK(n_fld, 2)
    `CHK(got_blk.size(), exp_blk.size())
    foreach (exp_blk[i])
      `CHK(got_blk[i], exp_blk[i])
    `CHK(got_pay.size(), exp_pay.size())
    foreach (exp_pay[i])
      `CHK(got_pay[i], exp_pay[i])
    for (int i = 0; i < 4; i++)
      enc_blk(tags[i], bits_tab[i], i + 1);
    `CHK(got_rcv.size(), exp_rcv.size())
    foreach (exp_rcv[i])
      `CHK(got_rcv[i], exp_rcv[i])
    finish_test();
  end
endmodule
